//--- hdl/acs_consts.vh
// constants of the converter sequencer: offsets, fields, resets, timing
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ACS_OFS_CTRL_A 8'h00
`define ACS_OFS_CTRL_B 8'h04
`define ACS_OFS_PINSEL 8'h08
`define ACS_OFS_PORTDIR 8'h0c
`define ACS_OFS_PULL 8'h10
`define ACS_OFS_PORTOUT 8'h14
`define ACS_OFS_PORTIN 8'h18
`define ACS_OFS_RES_HI 8'h1c
`define ACS_OFS_RES_LO 8'h20
`define ACS_OFS_IRQ 8'h24
// ------------------------------------------------------------
// converter_ctrl_a fields
// ------------------------------------------------------------
`define ACS_A_START 7
`define ACS_A_BUSY 6
`define ACS_A_POWER 5
`define ACS_A_ALIGN 4
`define ACS_A_CH_HI 3
`define ACS_A_CH_LO 0
// ------------------------------------------------------------
// converter_ctrl_b fields
// ------------------------------------------------------------
`define ACS_B_INT_HI 7
`define ACS_B_INT_LO 5
`define ACS_B_REF_HI 4
`define ACS_B_REF_LO 3
`define ACS_B_DIV_HI 2
`define ACS_B_DIV_LO 0
// ------------------------------------------------------------
// irq register fields
// ------------------------------------------------------------
`define ACS_I_FLAG 0
`define ACS_I_EN 1
`define ACS_I_GEN 2
// ------------------------------------------------------------
// codes
// ------------------------------------------------------------
`define ACS_REF_SUPPLY 2'h1
`define ACS_INT_BG 3'h1
`define ACS_INT_CUR 3'h2
`define ACS_INT_GND_A 3'h3
`define ACS_INT_GND_B 3'h4
// ------------------------------------------------------------
// reset values and the sar start code
// ------------------------------------------------------------
`define ACS_RST_BYTE 8'h00
`define ACS_RST_RES 12'h000
`define ACS_SAR_TOP 12'h800
// ------------------------------------------------------------
// timing in converter clock cycles
// ------------------------------------------------------------
`define ACS_SAMPLE_CYC 3'h4
`define ACS_CONV_CYC 4'hc
// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2
`endif

//--- hdl/acs_sequencer.v
// converter sequencer: axi4-lite registers, pin sharing, sample/convert fsm
`include "acs_consts.vh"

// Operation
// - analog-selected pin loses all other functions
// - pull-high removed on analog-selected pins
// - direction setting ignored on analog pins
// - reference from pin or supply by field
// - four sample plus twelve convert cycles
// - result latched half converter clock later
// - busy high during conversion, then result valid
// - power bit cleared keeps converter unpowered
// - twelve-bit result, full scale fff
// - code step is reference over 4096
// - start rise resets, start fall begins conversion
// - alignment bit selects result byte packing
// - divider field selects sysclk over 1..128
// - completion sets flag, raises enabled interrupt
module acs_sequencer #(
    parameter ADDR_W = 8,
    parameter PINS = 8
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire cmp_in,
    input wire [PINS-1:0] pad_in,
    output reg [PINS-1:0] pad_out,
    output reg [PINS-1:0] pad_oe,
    output reg [PINS-1:0] pad_pull_en,
    output reg [PINS-1:0] pin_analog_en,
    output reg adc_power_on,
    output reg adc_sample,
    output reg [11:0] adc_dac_code,
    output reg adc_ext_ch_en,
    output reg [3:0] adc_ext_ch_sel,
    output reg [2:0] adc_int_src_sel,
    output reg adc_ref_from_pin,
    output reg irq_req
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SAMPLE = 4'h2;
    localparam [3:0] ST_CONV = 4'h4;
    localparam [3:0] ST_LATCH = 4'h8;

    function [6:0] div_mask;
        input [2:0] code;
        begin
            div_mask = 7'h7f >> (3'h7 - code);
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg start_q, start_prev_q, power_q, align_q, busy_q;
    reg [3:0] ch_q;
    reg [2:0] int_src_q, div_q;
    reg [1:0] ref_q;
    reg [PINS-1:0] pinsel_q, dir_q, pull_q, dout_q;
    reg [PINS-1:0] pin_meta_q, pin_sync_q;
    reg cmp_meta_q, cmp_sync_q;
    reg [7:0] res_hi_q, res_lo_q;
    reg flag_q, irq_en_q, gen_q;
    reg [3:0] state_q;
    reg [6:0] div_cnt_q, half_cnt_q;
    reg [2:0] smp_cnt_q;
    reg [3:0] bit_idx_q;
    reg [11:0] sar_q;
    reg aw_hold_q, w_hold_q;
    reg [ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    wire start_rise = start_q & ~start_prev_q;
    wire start_fall = ~start_q & start_prev_q;
    wire [6:0] mask = div_mask(div_q);
    // tick marks the end of one converter clock period
    wire tick = (div_cnt_q & mask) == mask;
    wire wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire wr_lane = wr_fire & wstrb_q[0];
    wire [7:0] wbyte = wdata_q[7:0];
    // a restart or power-off in the last period must not set the flag
    wire done = power_q & ~start_rise & (state_q == ST_CONV) & tick &
        (bit_idx_q == 4'h0);
    wire [7:0] ctrl_a = {start_q, busy_q, power_q, align_q, ch_q};
    wire [7:0] ctrl_b = {int_src_q, ref_q, div_q};
    wire [7:0] irq_reg = {5'h00, gen_q, irq_en_q, flag_q};
    wire [7:0] port_in = pin_sync_q & ~pinsel_q;

    function mapped;
        input [ADDR_W-1:0] a;
        begin
            mapped = (a == `ACS_OFS_CTRL_A) | (a == `ACS_OFS_CTRL_B) |
                (a == `ACS_OFS_PINSEL) | (a == `ACS_OFS_PORTDIR) |
                (a == `ACS_OFS_PULL) | (a == `ACS_OFS_PORTOUT) |
                (a == `ACS_OFS_PORTIN) | (a == `ACS_OFS_RES_HI) |
                (a == `ACS_OFS_RES_LO) | (a == `ACS_OFS_IRQ);
        end
    endfunction

    // ------------------------------------------------------------
    // axi4-lite write and read channels
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ACS_RESP_OKAY;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `ACS_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            s_axi_awready <= ~aw_hold_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_hold_q & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_q) ? `ACS_RESP_OKAY :
                    `ACS_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
            s_axi_arready <= ~s_axi_rvalid &
                ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? `ACS_RESP_OKAY :
                    `ACS_RESP_SLVERR;
                case (s_axi_araddr)
                    `ACS_OFS_CTRL_A: s_axi_rdata <= {24'h000000, ctrl_a};
                    `ACS_OFS_CTRL_B: s_axi_rdata <= {24'h000000, ctrl_b};
                    `ACS_OFS_PINSEL: s_axi_rdata <= {24'h000000, pinsel_q};
                    `ACS_OFS_PORTDIR: s_axi_rdata <= {24'h000000, dir_q};
                    `ACS_OFS_PULL: s_axi_rdata <= {24'h000000, pull_q};
                    `ACS_OFS_PORTOUT: s_axi_rdata <= {24'h000000, dout_q};
                    `ACS_OFS_PORTIN: s_axi_rdata <= {24'h000000, port_in};
                    `ACS_OFS_RES_HI: s_axi_rdata <= {24'h000000, res_hi_q};
                    `ACS_OFS_RES_LO: s_axi_rdata <= {24'h000000, res_lo_q};
                    `ACS_OFS_IRQ: s_axi_rdata <= {24'h000000, irq_reg};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            start_prev_q <= 1'b0;
            power_q <= 1'b0;
            align_q <= 1'b0;
            ch_q <= 4'h0;
            int_src_q <= 3'h0;
            ref_q <= 2'h0;
            div_q <= 3'h0;
            pinsel_q <= `ACS_RST_BYTE;
            dir_q <= `ACS_RST_BYTE;
            pull_q <= `ACS_RST_BYTE;
            dout_q <= `ACS_RST_BYTE;
            irq_en_q <= 1'b0;
            gen_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            start_prev_q <= start_q;
            if (wr_lane && awaddr_q == `ACS_OFS_CTRL_A) begin
                start_q <= wbyte[`ACS_A_START];
                power_q <= wbyte[`ACS_A_POWER];
                align_q <= wbyte[`ACS_A_ALIGN];
                ch_q <= wbyte[`ACS_A_CH_HI:`ACS_A_CH_LO];
            end
            if (wr_lane && awaddr_q == `ACS_OFS_CTRL_B) begin
                int_src_q <= wbyte[`ACS_B_INT_HI:`ACS_B_INT_LO];
                ref_q <= wbyte[`ACS_B_REF_HI:`ACS_B_REF_LO];
                div_q <= wbyte[`ACS_B_DIV_HI:`ACS_B_DIV_LO];
            end
            if (wr_lane && awaddr_q == `ACS_OFS_PINSEL)
                pinsel_q <= wbyte;
            if (wr_lane && awaddr_q == `ACS_OFS_PORTDIR)
                dir_q <= wbyte;
            if (wr_lane && awaddr_q == `ACS_OFS_PULL)
                pull_q <= wbyte;
            if (wr_lane && awaddr_q == `ACS_OFS_PORTOUT)
                dout_q <= wbyte;
            if (wr_lane && awaddr_q == `ACS_OFS_IRQ) begin
                irq_en_q <= wbyte[`ACS_I_EN];
                gen_q <= wbyte[`ACS_I_GEN];
            end
            // completion sets flag; set beats a same-cycle clear
            if (done)
                flag_q <= 1'b1;
            else if (wr_lane && awaddr_q == `ACS_OFS_IRQ &&
                     !wbyte[`ACS_I_FLAG])
                flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // synchronisers for pad and comparator inputs
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= {PINS{1'b0}};
            pin_sync_q <= {PINS{1'b0}};
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= pad_in;
            pin_sync_q <= pin_meta_q;
            cmp_meta_q <= cmp_in;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            div_cnt_q <= 7'h00;
            half_cnt_q <= 7'h00;
            smp_cnt_q <= 3'h0;
            bit_idx_q <= 4'h0;
            sar_q <= `ACS_RST_RES;
            busy_q <= 1'b0;
            res_hi_q <= `ACS_RST_BYTE;
            res_lo_q <= `ACS_RST_BYTE;
        end else if (!power_q) begin
            state_q <= ST_IDLE;
            div_cnt_q <= 7'h00;
            smp_cnt_q <= 3'h0;
            bit_idx_q <= 4'h0;
            busy_q <= 1'b0;
        end else if (start_rise) begin
            state_q <= ST_IDLE;
            div_cnt_q <= 7'h00;
            sar_q <= `ACS_RST_RES;
            busy_q <= 1'b0;
        end else begin
            div_cnt_q <= tick ? 7'h00 : div_cnt_q + 7'h01;
            case (state_q)
                ST_IDLE: begin
                    if (start_fall) begin
                        state_q <= ST_SAMPLE;
                        div_cnt_q <= 7'h00;
                        smp_cnt_q <= 3'h0;
                        busy_q <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        smp_cnt_q <= smp_cnt_q + 3'h1;
                        if (smp_cnt_q == `ACS_SAMPLE_CYC - 3'h1) begin
                            state_q <= ST_CONV;
                            sar_q <= `ACS_SAR_TOP;
                            bit_idx_q <= `ACS_CONV_CYC - 4'h1;
                        end
                    end
                end
                ST_CONV: begin
                    // twelve trial periods, one bit each
                    if (tick) begin
                        sar_q[bit_idx_q] <= cmp_sync_q;
                        if (bit_idx_q != 4'h0) begin
                            sar_q[bit_idx_q - 4'h1] <= 1'b1;
                            bit_idx_q <= bit_idx_q - 4'h1;
                        end else begin
                            state_q <= ST_LATCH;
                            busy_q <= 1'b0;
                            half_cnt_q <= 7'h00;
                        end
                    end
                end
                ST_LATCH: begin
                    // result pair follows converter until latched
                    half_cnt_q <= half_cnt_q + 7'h01;
                    if (half_cnt_q >= (mask >> 1))
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
            if (state_q == ST_LATCH) begin
                if (align_q) begin
                    res_hi_q <= {4'h0, sar_q[11:8]};
                    res_lo_q <= sar_q[7:0];
                end else begin
                    res_hi_q <= sar_q[11:4];
                    res_lo_q <= {sar_q[3:0], 4'h0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pin sharing and analog controls
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= {PINS{1'b0}};
            pad_oe <= {PINS{1'b0}};
            pad_pull_en <= {PINS{1'b0}};
            pin_analog_en <= {PINS{1'b0}};
            adc_power_on <= 1'b0;
            adc_sample <= 1'b0;
            adc_dac_code <= `ACS_RST_RES;
            adc_ext_ch_en <= 1'b0;
            adc_ext_ch_sel <= 4'h0;
            adc_int_src_sel <= 3'h0;
            adc_ref_from_pin <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            pad_out <= dout_q & ~pinsel_q;
            pad_oe <= dir_q & ~pinsel_q;
            pad_pull_en <= pull_q & ~pinsel_q;
            pin_analog_en <= pinsel_q;
            // analog circuits only powered by the enable bit
            adc_power_on <= power_q;
            adc_sample <= (state_q == ST_SAMPLE);
            // twelve-bit trial code; offsets live in the analog
            adc_dac_code <= (state_q == ST_CONV) ? sar_q : `ACS_RST_RES;
            // internal source switches the external channel off
            adc_ext_ch_en <= ~((int_src_q == `ACS_INT_BG) |
                (int_src_q == `ACS_INT_CUR) |
                (int_src_q == `ACS_INT_GND_A) |
                (int_src_q == `ACS_INT_GND_B));
            adc_ext_ch_sel <= ch_q;
            adc_int_src_sel <= int_src_q;
            adc_ref_from_pin <= (ref_q != `ACS_REF_SUPPLY);
            irq_req <= flag_q & irq_en_q & gen_q;
        end
    end
endmodule

//--- tb/acs_seq_assertions.sv
// checker of the converter sequencer port behaviour
module acs_seq_assertions #(
    parameter PINS = 8
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [PINS-1:0] pad_out,
    input wire [PINS-1:0] pad_oe,
    input wire [PINS-1:0] pad_pull_en,
    input wire [PINS-1:0] pin_analog_en,
    input wire adc_power_on,
    input wire adc_sample,
    input wire [11:0] adc_dac_code,
    input wire adc_ext_ch_en,
    input wire [2:0] adc_int_src_sel
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    pad_out_a: assert property ((pad_out & pin_analog_en) == '0)
        else $error("port data reaches an analog pin");
    pull_off_a: assert property ((pad_pull_en & pin_analog_en) == '0)
        else $error("pull-high left on an analog pin");
    dir_ignored_a: assert property ((pad_oe & pin_analog_en) == '0)
        else $error("analog pin still driven");
    ext_off_a: assert property (adc_int_src_sel inside {[1:4]}
        |-> !adc_ext_ch_en) else $error("external channel not cut off");
    sample_len_a: assert property ($rose(adc_sample) |-> adc_sample[*4])
        else $error("sample phase shorter than four cycles");
    sample_dac_a: assert property (adc_sample |-> adc_dac_code == 12'h000)
        else $error("trial code during sampling");
    power_off_a: assert property (!adc_power_on && !$past(adc_power_on)
        && !$past(adc_power_on, 2) |-> !adc_sample && adc_dac_code == 12'h000)
        else $error("converter active while unpowered");
    // power-up does not start a phase
    power_up_a: assert property ($rose(adc_power_on) |-> !adc_sample[*2])
        else $error("sampling began at power-up");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
    rdata_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
        else $error("read data above bit 7");
endmodule

bind acs_sequencer acs_seq_assertions #(.PINS(PINS)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .pin_analog_en(pin_analog_en),
    .adc_power_on(adc_power_on), .adc_sample(adc_sample),
    .adc_dac_code(adc_dac_code), .adc_ext_ch_en(adc_ext_ch_en),
    .adc_int_src_sel(adc_int_src_sel));

//--- tb/adc_conversion_sequencer_bench.sv
// self-checking bench of the converter sequencer
`include "acs_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module adc_conversion_sequencer_bench;
timeunit 1ns;
timeprecision 1ps;
logic clk_sys = 0, rst_n = 0, cmp_in = 0;
logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pad_in = 8'hff;
logic [31:0] s_axi_wdata = 0;
logic [3:0] s_axi_wstrb = 4'hf;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp, rs;
logic [31:0] s_axi_rdata;
logic [7:0] pad_out, pad_oe, pad_pull_en, pin_analog_en, rd, eh, el;
logic adc_power_on, adc_sample, adc_ext_ch_en, adc_ref_from_pin, irq_req;
logic [11:0] adc_dac_code, v;
logic [3:0] adc_ext_ch_sel;
logic [2:0] adc_int_src_sel;
int n_errors = 0, samples_checked = 0, n_samp = 0, n_conv = 0;

always #2 clk_sys = ~clk_sys;
// phase lengths are measured at the ports, not trusted to the bus polling
always @(posedge clk_sys) begin
    if (adc_sample === 1'b1) n_samp++;
    if (adc_dac_code !== 12'h000) n_conv++;
end

acs_sequencer DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cmp_in(cmp_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pin_analog_en(pin_analog_en), .adc_power_on(adc_power_on),
    .adc_sample(adc_sample), .adc_dac_code(adc_dac_code),
    .adc_ext_ch_en(adc_ext_ch_en), .adc_ext_ch_sel(adc_ext_ch_sel),
    .adc_int_src_sel(adc_int_src_sel), .adc_ref_from_pin(adc_ref_from_pin),
    .irq_req(irq_req));

// ------------------------------------------------------------
// bus master and run control
// ------------------------------------------------------------
task end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask
task tmo;
    n_errors++;
    $display("BAD %0t timeout", $time);
    end_sim;
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    // bready trails bvalid by a cycle so the answer must stand
    for (i = 0; i < 100; i++) begin
        @(posedge clk_sys);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
        if (s_axi_bvalid === 1'b1) s_axi_bready <= 1;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    if (i == 100) tmo;
endtask
task automatic rdr(input logic [7:0] a);
    int i;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (i = 0; i < 100; i++) begin
        @(posedge clk_sys);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
        if (s_axi_rvalid === 1'b1) s_axi_rready <= 1;
    end
    rd = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    if (i == 100) tmo;
endtask
task automatic wait_done;
    int i;
    for (i = 0; i < 2000; i++) begin
        rdr(`ACS_OFS_CTRL_A);
        if (rd[`ACS_A_BUSY] === 1'b0) break;
    end
    if (i == 2000) tmo;
endtask

// ------------------------------------------------------------
// scenarios
// ------------------------------------------------------------
task automatic t_reset;
    for (int a = 0; a < 8'h18; a += 4) begin
        rdr(a[7:0]);
        `CHK(rd, 8'h00)
    end
    rdr(8'h28);
    `CHK(rs, `ACS_RESP_SLVERR)
    wr(8'h28, 8'h55);
    `CHK(rs, `ACS_RESP_SLVERR)
    $display("test reset done");
endtask
task automatic t_pins;
    wr(`ACS_OFS_PINSEL, 8'h0f);
    wr(`ACS_OFS_PORTDIR, 8'hff);
    wr(`ACS_OFS_PULL, 8'hff);
    wr(`ACS_OFS_PORTOUT, 8'hff);
    wr(`ACS_OFS_CTRL_B, 8'h28);
    repeat (3) @(posedge clk_sys);
    `CHK(adc_int_src_sel, 3'h1)
    `CHK(pad_oe, 8'hf0)
    `CHK(pad_pull_en, 8'hf0)
    `CHK(pad_out, 8'hf0)
    `CHK(pin_analog_en, 8'h0f)
    `CHK(adc_ext_ch_en, 1'b0)
    `CHK(adc_ref_from_pin, 1'b0)
    rdr(`ACS_OFS_PORTIN);
    `CHK(rd, 8'hf0)
    // reference pin share set with port
    wr(`ACS_OFS_CTRL_B, 8'h00);
    wr(`ACS_OFS_CTRL_A, 8'h03);
    repeat (3) @(posedge clk_sys);
    `CHK(adc_ext_ch_sel, 4'h3)
    `CHK(adc_int_src_sel, 3'h0)
    `CHK(adc_ref_from_pin, 1'b1)
    `CHK(adc_ext_ch_en, 1'b1)
    $display("test pins done");
endtask
// every divider code, both packings, both extreme codes
task automatic t_conv;
    // power, then pins, then divider on each pass
    wr(`ACS_OFS_CTRL_A, 8'h20);
    wr(`ACS_OFS_PINSEL, 8'h0f);
    for (int d = 0; d < 8; d++) begin
        cmp_in <= d[1];
        v = d[1] ? 12'hfff : 12'h000;
        eh = d[0] ? {4'h0, v[11:8]} : v[11:4];
        el = d[0] ? v[7:0] : {v[3:0], 4'h0};
        wr(`ACS_OFS_IRQ, 8'h06);
        wr(`ACS_OFS_CTRL_B, {5'h00, d[2:0]});
        wr(`ACS_OFS_CTRL_A, {3'h5, d[0], 4'h0});
        n_samp = 0;
        n_conv = 0;
        wr(`ACS_OFS_CTRL_A, {3'h1, d[0], 4'h0});
        rdr(`ACS_OFS_CTRL_A);
        `CHK(rd[`ACS_A_BUSY], 1'b1)
        wait_done;
        `CHK(n_samp, 4 << d)
        `CHK(n_conv, 12 << d)
        `CHK(irq_req, 1'b1)
        rdr(`ACS_OFS_RES_HI);
        `CHK(rd, eh)
        rdr(`ACS_OFS_RES_LO);
        `CHK(rd, el)
        wr(`ACS_OFS_IRQ, 8'h06);
        repeat (3) @(posedge clk_sys);
        `CHK(irq_req, 1'b0)
        repeat (1 << d) @(posedge clk_sys);
    end
    $display("test conversion done");
endtask
// restart in mid-conversion, then power removed
task automatic t_abort;
    wr(`ACS_OFS_CTRL_B, 8'h07);
    wr(`ACS_OFS_CTRL_A, 8'ha0);
    wr(`ACS_OFS_CTRL_A, 8'h20);
    wr(`ACS_OFS_CTRL_A, 8'ha0);
    rdr(`ACS_OFS_CTRL_A);
    `CHK(rd[`ACS_A_BUSY], 1'b0)
    `CHK(adc_sample, 1'b0)
    wr(`ACS_OFS_CTRL_A, 8'h20);
    rdr(`ACS_OFS_CTRL_A);
    `CHK(rd[`ACS_A_BUSY], 1'b1)
    wr(`ACS_OFS_CTRL_A, 8'h00);
    repeat (3) @(posedge clk_sys);
    `CHK(adc_power_on, 1'b0)
    `CHK(adc_sample, 1'b0)
    wr(`ACS_OFS_CTRL_A, 8'h80);
    wr(`ACS_OFS_CTRL_A, 8'h00);
    repeat (100) @(posedge clk_sys);
    rdr(`ACS_OFS_CTRL_A);
    `CHK(rd[`ACS_A_BUSY], 1'b0)
    rdr(`ACS_OFS_IRQ);
    `CHK(rd[`ACS_I_FLAG], 1'b0)
    $display("test abort done");
endtask

initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    t_reset;
    t_pins;
    t_conv;
    t_abort;
    end_sim;
end
endmodule
